// [core/dcf_pkg.sv]
// Shared constants for the dual clock flagged FIFO.
// Assumes one write clock and one read clock, with no fixed phase relation.
package dcf_pkg;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int DATA_W = 18;
  localparam int DIST_W = 16;
  localparam int ADDR_W_DEF = 13;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DIST_W-1:0] EMPTY_DIST_RST = 16'h007F;
  localparam logic [DIST_W-1:0] FULL_DIST_RST = 16'h007F;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;

  // ****************************************
  // Distance register selection sequence
  // ****************************************
  typedef enum logic {
    DCF_SEL_EMPTY = 1'b0,
    DCF_SEL_FULL = 1'b1
  } dcf_sel_t;

endpackage : dcf_pkg

// [core/dcf_fifo.sv]
// Dual clock FIFO with empty, full, half-full and programmable almost flags.
// Assumes the writing agent runs on core_clk_in and the reading agent on rd_clk_in.
// The read data pins are resolved to high impedance outside, from read_data_oe_out.
//
// Behaviour
// - Storage holds a power-of-two count of 18-bit words, with read and write pointers.
// - Each write clock edge with write enable low stores the input word.
// - Each read clock edge with read enable low presents the next stored word.
// - Reset empties the buffer and drives the empty flag low.
// - After reset the read data reads all low while output enable is low.
// - Output enable high floats the read data; low drives the output register.
// - When cascaded, only the device holding the read token drives its read data.
// - Writes are ignored while the full flag is low.
// - Reads are ignored while the empty flag is low.
// - An empty buffer keeps the last validly read word on its outputs.
// - Two 16-bit distance registers, loaded from input bits 0 to 15, place almost flags.
// - Program writes cycle empty distance, full distance, empty distance again.
// - Raising load returns to normal; a later load writes the next register.
// - Program reads return the distance registers in the same sequence.
// - Unprogrammed distance registers hold built-in default values.
// - Full flag goes low at full depth and changes only on write clock edges.
// - Empty flag goes low with no words and changes only on read clock edges.
// - Empty and full are always synchronous; almost flags only in synchronous mode.
// - In synchronous mode almost full follows write clock, almost empty read clock.
// - Almost empty low from 0 to n words; almost full low within m of full.
// - Half full is high up to half depth and low from half plus one.
`timescale 1ns/100ps

module dcf_fifo #(
  parameter int ADDR_W = dcf_pkg::ADDR_W_DEF
) (
  input wire logic core_clk_in, // Write clock
  input wire logic rd_clk_in, // Read clock
  input wire logic rst_b_in, // Reset, active low, asynchronous
  input wire logic write_enable_n_in, // Write enable, active low
  input wire logic [dcf_pkg::DATA_W-1:0] write_data_in, // Write word
  input wire logic load_n_in, // Distance register access, active low
  input wire logic read_enable_n_in, // Read enable, active low
  input wire logic output_enable_n_in, // Output enable, active low
  input wire logic read_cascade_in, // Read token, high when this device reads
  input wire logic flag_sync_mode_n_in, // Low selects synchronous almost flags
  output logic [dcf_pkg::DATA_W-1:0] read_data_out, // Output register
  output logic read_data_oe_out, // High while read data is driven
  output logic empty_flag_n_out, // Empty, active low
  output logic full_flag_n_out, // Full, active low
  output logic half_full_n_out, // More than half full, active low
  output logic almost_empty_n_out, // Almost empty, active low
  output logic almost_full_n_out // Almost full, active low
);

  // ****************************************
  // Sizes and helpers
  // ****************************************
  localparam int PW = ADDR_W + 1;
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [31:0] DEPTH_W = 32'(DEPTH);
  localparam logic [31:0] HALF_W = 32'(DEPTH / 2);

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  logic [dcf_pkg::DATA_W-1:0] mem [DEPTH];

  // ****************************************
  // Write domain
  // ****************************************
  logic [PW-1:0] wbin_reg;
  logic [PW-1:0] wgray_reg;
  logic [PW-1:0] rgray_s1_reg;
  logic [PW-1:0] rgray_s2_reg;
  logic wmode_s1_reg;
  logic wmode_s2_reg;
  logic full_n_reg;
  logic half_n_reg;
  logic afull_n_reg;
  logic [dcf_pkg::DIST_W-1:0] empty_dist_reg;
  logic [dcf_pkg::DIST_W-1:0] full_dist_reg;
  dcf_pkg::dcf_sel_t wsel_reg;
  logic dist_tog_reg;
  logic [PW-1:0] rgray_q_reg; // Driven by the read domain, declared here for the crossing
  logic [PW-1:0] rbin_w;
  logic [PW-1:0] wbin_next;
  logic [PW-1:0] wdiff_next;
  logic [PW-1:0] wdiff_now;
  logic [31:0] wfill_next;
  logic [31:0] wfill_now;
  logic wr_do;
  logic prog_wr;

  // A full buffer refuses the write; programming takes the port instead
  assign wr_do = ~write_enable_n_in & load_n_in & full_n_reg;
  assign prog_wr = ~write_enable_n_in & ~load_n_in;
  assign rbin_w = gray2bin(rgray_s2_reg);
  assign wbin_next = wbin_reg + PW'(wr_do);
  // Differences stay at pointer width, so the count is right after a wrap
  assign wdiff_next = wbin_next - rbin_w;
  assign wdiff_now = wbin_reg - rbin_w;
  assign wfill_next = 32'(wdiff_next);
  assign wfill_now = 32'(wdiff_now);

  always_ff @(posedge core_clk_in) begin
    if (wr_do) begin
      mem[wbin_reg[ADDR_W-1:0]] <= write_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wbin_reg <= '0;
      wgray_reg <= '0;
    end else begin
      wbin_reg <= wbin_next;
      wgray_reg <= bin2gray(wbin_next);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rgray_s1_reg <= '0;
      rgray_s2_reg <= '0;
    end else begin
      rgray_s1_reg <= rgray_q_reg;
      rgray_s2_reg <= rgray_s1_reg;
    end
  end

  // Mode pin passes two flops before the write side reads it
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wmode_s1_reg <= 1'b0;
      wmode_s2_reg <= 1'b0;
    end else begin
      wmode_s1_reg <= flag_sync_mode_n_in;
      wmode_s2_reg <= wmode_s1_reg;
    end
  end

  // Flags of the write side move only on write clock edges
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      full_n_reg <= 1'b1;
      half_n_reg <= 1'b1;
      afull_n_reg <= 1'b1;
    end else begin
      full_n_reg <= (wfill_next != DEPTH_W);
      half_n_reg <= (wfill_next <= HALF_W);
      afull_n_reg <= (wfill_next + 32'(full_dist_reg) < DEPTH_W);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      empty_dist_reg <= dcf_pkg::EMPTY_DIST_RST;
      full_dist_reg <= dcf_pkg::FULL_DIST_RST;
      wsel_reg <= dcf_pkg::DCF_SEL_EMPTY;
      dist_tog_reg <= 1'b0;
    end else if (prog_wr) begin
      // The selection survives load going high, so a later load resumes it
      case (wsel_reg)
        dcf_pkg::DCF_SEL_EMPTY: begin
          empty_dist_reg <= write_data_in[dcf_pkg::DIST_W-1:0];
          wsel_reg <= dcf_pkg::DCF_SEL_FULL;
        end
        dcf_pkg::DCF_SEL_FULL: begin
          full_dist_reg <= write_data_in[dcf_pkg::DIST_W-1:0];
          wsel_reg <= dcf_pkg::DCF_SEL_EMPTY;
        end
        default: begin
          wsel_reg <= dcf_pkg::DCF_SEL_EMPTY;
        end
      endcase
      dist_tog_reg <= ~dist_tog_reg;
    end
  end

  // ****************************************
  // Read domain
  // ****************************************
  logic [PW-1:0] rbin_reg;
  logic [PW-1:0] wgray_s1_reg;
  logic [PW-1:0] wgray_s2_reg;
  logic rmode_s1_reg;
  logic rmode_s2_reg;
  logic load_s1_reg;
  logic load_s2_reg;
  logic oe_s1_reg;
  logic oe_s2_reg;
  logic casc_s1_reg;
  logic casc_s2_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic empty_n_reg;
  logic aempty_n_reg;
  logic [dcf_pkg::DIST_W-1:0] empty_dist_rd_reg;
  logic [dcf_pkg::DIST_W-1:0] full_dist_rd_reg;
  dcf_pkg::dcf_sel_t rsel_reg;
  logic [dcf_pkg::DATA_W-1:0] rdata_reg;
  logic [PW-1:0] wbin_r;
  logic [PW-1:0] rbin_next;
  logic [PW-1:0] rdiff_next;
  logic [PW-1:0] rdiff_now;
  logic [31:0] rfill_next;
  logic [31:0] rfill_now;
  logic rd_do;
  logic prog_rd;

  // An empty buffer refuses the read and the output register holds
  assign rd_do = ~read_enable_n_in & load_s2_reg & empty_n_reg;
  assign prog_rd = ~read_enable_n_in & ~load_s2_reg;
  assign wbin_r = gray2bin(wgray_s2_reg);
  assign rbin_next = rbin_reg + PW'(rd_do);
  // Same width rule as the write side: wrap must not turn into a huge count
  assign rdiff_next = wbin_r - rbin_next;
  assign rdiff_now = wbin_r - rbin_reg;
  assign rfill_next = 32'(rdiff_next);
  assign rfill_now = 32'(rdiff_now);

  always_ff @(posedge rd_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rbin_reg <= '0;
      rgray_q_reg <= '0;
    end else begin
      rbin_reg <= rbin_next;
      rgray_q_reg <= bin2gray(rbin_next);
    end
  end

  always_ff @(posedge rd_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wgray_s1_reg <= '0;
      wgray_s2_reg <= '0;
    end else begin
      wgray_s1_reg <= wgray_reg;
      wgray_s2_reg <= wgray_s1_reg;
    end
  end

  // Mode, load, output enable and cascade pins pass two flops before read-side logic sees them
  always_ff @(posedge rd_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rmode_s1_reg <= 1'b0;
      rmode_s2_reg <= 1'b0;
      load_s1_reg <= 1'b1;
      load_s2_reg <= 1'b1;
      oe_s1_reg <= 1'b1;
      oe_s2_reg <= 1'b1;
      casc_s1_reg <= 1'b0;
      casc_s2_reg <= 1'b0;
    end else begin
      rmode_s1_reg <= flag_sync_mode_n_in;
      rmode_s2_reg <= rmode_s1_reg;
      load_s1_reg <= load_n_in;
      load_s2_reg <= load_s1_reg;
      oe_s1_reg <= output_enable_n_in;
      oe_s2_reg <= oe_s1_reg;
      casc_s1_reg <= read_cascade_in;
      casc_s2_reg <= casc_s1_reg;
    end
  end

  // Distances cross by toggle; the words are stable long before it arrives
  always_ff @(posedge rd_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
      empty_dist_rd_reg <= dcf_pkg::EMPTY_DIST_RST;
      full_dist_rd_reg <= dcf_pkg::FULL_DIST_RST;
    end else begin
      tog_s1_reg <= dist_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      if (tog_s2_reg != tog_s3_reg) begin
        empty_dist_rd_reg <= empty_dist_reg;
        full_dist_rd_reg <= full_dist_reg;
      end
    end
  end

  // Flags of the read side move only on read clock edges
  always_ff @(posedge rd_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      empty_n_reg <= 1'b0;
      aempty_n_reg <= 1'b0;
    end else begin
      empty_n_reg <= (rfill_next != 32'd0);
      aempty_n_reg <= (rfill_next > 32'(empty_dist_rd_reg));
    end
  end

  always_ff @(posedge rd_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= dcf_pkg::DATA_RST;
      rsel_reg <= dcf_pkg::DCF_SEL_EMPTY;
    end else if (prog_rd) begin
      case (rsel_reg)
        dcf_pkg::DCF_SEL_EMPTY: begin
          rdata_reg <= dcf_pkg::DATA_W'(empty_dist_rd_reg);
          rsel_reg <= dcf_pkg::DCF_SEL_FULL;
        end
        dcf_pkg::DCF_SEL_FULL: begin
          rdata_reg <= dcf_pkg::DATA_W'(full_dist_rd_reg);
          rsel_reg <= dcf_pkg::DCF_SEL_EMPTY;
        end
        default: begin
          rsel_reg <= dcf_pkg::DCF_SEL_EMPTY;
        end
      endcase
    end else if (rd_do) begin
      rdata_reg <= mem[rbin_reg[ADDR_W-1:0]];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign read_data_out = rdata_reg;
  // Only the device holding the read token drives the shared data lines
  assign read_data_oe_out = ~oe_s2_reg & casc_s2_reg;
  assign empty_flag_n_out = empty_n_reg;
  assign full_flag_n_out = full_n_reg;
  assign half_full_n_out = half_n_reg;
  // Asynchronous mode follows the pointers as soon as the crossed copy moves
  assign almost_full_n_out = wmode_s2_reg ?
    (wfill_now + 32'(full_dist_reg) < DEPTH_W) : afull_n_reg;
  assign almost_empty_n_out = rmode_s2_reg ?
    (rfill_now > 32'(empty_dist_rd_reg)) : aempty_n_reg;

endmodule : dcf_fifo

// [verification/dcf_fifo_monitor.sv]
// Port checker for the dual clock FIFO, bound to dcf_fifo.
// Assumes synchronous almost flags and no program access while reads are checked.
`timescale 1ns/100ps
module dcf_fifo_monitor (
  input wire logic core_clk_in, // Write clock
  input wire logic rd_clk_in, // Read clock
  input wire logic rst_b_in, // Reset
  input wire logic write_enable_n_in, // Write enable
  input wire logic read_enable_n_in, // Read enable
  input wire logic load_n_in, // Distance access
  input wire logic output_enable_n_in, // Output enable
  input wire logic read_cascade_in, // Read token
  input wire logic [dcf_pkg::DATA_W-1:0] read_data_out, // Read word
  input wire logic read_data_oe_out, // Drive enable
  input wire logic empty_flag_n_out, // Empty
  input wire logic full_flag_n_out, // Full
  input wire logic half_full_n_out, // Half full
  input wire logic almost_empty_n_out, // Almost empty
  input wire logic almost_full_n_out // Almost full
);
  // ****
  // Sequences
  // ****
  sequence s_oe_off; output_enable_n_in [*4]; endsequence
  sequence s_tok_off; !read_cascade_in [*4]; endsequence
  sequence s_oe_on; (!output_enable_n_in && read_cascade_in) [*4]; endsequence
  // Load must be seen high long enough to clear its two-flop crossing
  sequence s_idle_empty; load_n_in [*3] ##0 !empty_flag_n_out; endsequence
  // ****
  // Properties
  // ****
  // Reset is the cause here, so it cannot also disable the check
  property p_rst;
    @(posedge core_clk_in) !rst_b_in |-> !empty_flag_n_out && full_flag_n_out
      && read_data_out == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_oe_off;
    @(posedge rd_clk_in) disable iff (!rst_b_in) s_oe_off |-> !read_data_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driven while disabled");
  property p_tok_off;
    @(posedge rd_clk_in) disable iff (!rst_b_in) s_tok_off |-> !read_data_oe_out;
  endproperty
  a_tok_off: assert property (p_tok_off) else $error("driven without token");
  property p_oe_on;
    @(posedge rd_clk_in) disable iff (!rst_b_in) s_oe_on |-> read_data_oe_out;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("not driven when enabled");
  property p_empty_hold;
    @(posedge rd_clk_in) disable iff (!rst_b_in) s_idle_empty |=> $stable(read_data_out);
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("data moved while empty");
  property p_empty_fall;
    @(posedge rd_clk_in) disable iff (!rst_b_in)
      $fell(empty_flag_n_out) |-> !$past(read_enable_n_in);
  endproperty
  a_empty_fall: assert property (p_empty_fall) else $error("empty without read");
  property p_full_fall;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      $fell(full_flag_n_out) |-> !$past(write_enable_n_in);
  endproperty
  a_full_fall: assert property (p_full_fall) else $error("full without write");
  property p_full_flags;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      !full_flag_n_out |-> !half_full_n_out && !almost_full_n_out;
  endproperty
  a_full_flags: assert property (p_full_flags) else $error("flags disagree at full");
  property p_empty_ae;
    @(posedge rd_clk_in) disable iff (!rst_b_in) !empty_flag_n_out |-> !almost_empty_n_out;
  endproperty
  a_empty_ae: assert property (p_empty_ae) else $error("almost empty off at empty");
endmodule : dcf_fifo_monitor

// [verification/dcf_rd_agent.sv]
// Reading agent on the output port of the FIFO.
// Assumes the bench paces read requests on the read clock.
`timescale 1ns/100ps
module dcf_rd_agent (
  input wire logic rst_b_in, // Reset
  input wire logic rd_req_in, // Read request
  input wire logic read_data_oe_in, // Device drives pins
  input wire logic [dcf_pkg::DATA_W-1:0] read_data_in, // Device word
  output logic read_enable_n_out, // Read enable
  output logic [dcf_pkg::DATA_W-1:0] q_pins_out // Pins as seen
);
  // Never reads while reset is held
  assign read_enable_n_out = !(rst_b_in && rd_req_in);
  // Released pins show garbage, so a floating bus never passes for data
  assign q_pins_out = read_data_oe_in ? read_data_in : ~read_data_in;
endmodule : dcf_rd_agent

// [verification/test_dual_clock_flagged_fifo.sv]
// Self-checking bench for the dual clock FIFO, 16 words deep.
// Assumes dcf_pkg, dcf_fifo, the checker and the read agent are compiled first.
`timescale 1ns/100ps
module test_dual_clock_flagged_fifo;
  localparam int DEP = 16;
  logic core_clk_in = 1'b0;
  logic rd_clk_in = 1'b0;
  logic rst_b_in = 1'b1;
  logic write_enable_n_in = 1'b1;
  logic [17:0] write_data_in = '0;
  logic load_n_in = 1'b1;
  logic output_enable_n_in = 1'b0;
  logic read_cascade_in = 1'b1;
  logic flag_sync_mode_n_in = 1'b0;
  logic rd_req = 1'b0;
  wire read_enable_n_in, read_data_oe_out, empty_flag_n_out, full_flag_n_out;
  wire half_full_n_out, almost_empty_n_out, almost_full_n_out;
  wire [17:0] read_data_out, q_pins;
  int n_fail = 0;
  int checks_done = 0;
  always #20 core_clk_in = ~core_clk_in;
  always #3 rd_clk_in = ~rd_clk_in;
  dcf_fifo #(.ADDR_W(4)) uut (
    .core_clk_in(core_clk_in),
    .rd_clk_in(rd_clk_in),
    .rst_b_in(rst_b_in),
    .write_enable_n_in(write_enable_n_in),
    .write_data_in(write_data_in),
    .load_n_in(load_n_in),
    .read_enable_n_in(read_enable_n_in),
    .output_enable_n_in(output_enable_n_in),
    .read_cascade_in(read_cascade_in),
    .flag_sync_mode_n_in(flag_sync_mode_n_in),
    .read_data_out(read_data_out),
    .read_data_oe_out(read_data_oe_out),
    .empty_flag_n_out(empty_flag_n_out),
    .full_flag_n_out(full_flag_n_out),
    .half_full_n_out(half_full_n_out),
    .almost_empty_n_out(almost_empty_n_out),
    .almost_full_n_out(almost_full_n_out)
  );
  dcf_rd_agent u_agent (.rst_b_in(rst_b_in), .rd_req_in(rd_req),
    .read_data_oe_in(read_data_oe_out), .read_data_in(read_data_out),
    .read_enable_n_out(read_enable_n_in), .q_pins_out(q_pins));
  // ****
  // Tasks
  // ****
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  task chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic ld, input logic [17:0] d);
    @(posedge core_clk_in);
    load_n_in <= ld;
    write_enable_n_in <= 1'b0;
    write_data_in <= d;
    @(posedge core_clk_in);
    write_enable_n_in <= 1'b1;
    load_n_in <= 1'b1;
    #1;
  endtask : wr
  task rd;
    @(posedge rd_clk_in);
    rd_req <= 1'b1;
    @(posedge rd_clk_in);
    rd_req <= 1'b0;
    #1;
  endtask : rd
  task prog_rd(input logic [17:0] e0, input logic [17:0] e1);
    @(posedge core_clk_in);
    load_n_in <= 1'b0;
    repeat (6) @(posedge rd_clk_in);
    rd();
    chk(read_data_out, e0);
    rd();
    chk(read_data_out, e1);
    @(posedge core_clk_in);
    load_n_in <= 1'b1;
    repeat (6) @(posedge rd_clk_in);
  endtask : prog_rd
  task wait_ne;
    for (int i = 0; i < 40 && empty_flag_n_out !== 1'b1; i++) @(posedge rd_clk_in);
    #1;
    if (empty_flag_n_out !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t empty flag stuck", $time);
      stop_test();
    end
  endtask : wait_ne
  // ****
  // Sequence
  // ****
  initial begin
    // Writes stay idle and the agent stays quiet through reset
    // A falling edge at time zero starts the asynchronous reset
    rst_b_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    #1;
    chk(18'({empty_flag_n_out, full_flag_n_out, half_full_n_out}), 18'h0_0003);
    chk(read_data_out, 18'h0_0000);
    repeat (10) @(posedge rd_clk_in);
    #1 chk(q_pins, 18'h0_0000);
    for (int i = 0; i < 2; i++) begin
      @(posedge rd_clk_in);
      {output_enable_n_in, read_cascade_in} <= i ? 2'b11 : 2'b00;
      repeat (5) @(posedge rd_clk_in);
      #1 chk(18'(read_data_oe_out), 18'h0_0000);
      @(posedge rd_clk_in);
      {output_enable_n_in, read_cascade_in} <= 2'b01;
    end
    $display("test reset and output enable done");
    prog_rd(18'h0_007F, 18'h0_007F);
    wr(1'b0, 18'h3_0007);
    wr(1'b0, 18'h3_0003);
    wr(1'b0, 18'h3_0002);
    prog_rd(18'h0_0002, 18'h0_0003);
    $display("test distance registers done");
    for (int k = 1; k <= 5; k++) wr(1'b1, 18'h0_0100 + 18'(k));
    wait_ne();
    for (int k = 1; k <= 5; k++) begin
      rd();
      chk(q_pins, 18'h0_0100 + 18'(k));
    end
    $display("test offset pointers done");
    // The second pass carries both pointers past their top bit
    for (int p = 0; p < 2; p++) begin
      repeat (4) @(posedge core_clk_in);
      for (int k = 1; k <= DEP; k++) begin
        wr(1'b1, 18'h2_5A00 + 18'(k));
        chk(18'({full_flag_n_out, half_full_n_out, almost_full_n_out}),
          18'({k < DEP, k <= DEP / 2, k < DEP - 3}));
      end
      wr(1'b1, 18'h1_1111);
      wait_ne();
      for (int k = 1; k <= DEP; k++) begin
        rd();
        chk(q_pins, 18'h2_5A00 + 18'(k));
        chk(18'({empty_flag_n_out, almost_empty_n_out}),
          18'({k < DEP, DEP - k > 2}));
      end
      rd();
      chk(q_pins, 18'h2_5A10);
      $display("test fill and drain pass %0d done", p);
    end
    // Asynchronous almost flags follow the crossed pointers directly
    @(posedge core_clk_in);
    flag_sync_mode_n_in <= 1'b1;
    for (int k = 1; k <= 3; k++) wr(1'b1, 18'h0_0200 + 18'(k));
    repeat (8) @(posedge rd_clk_in);
    #1 chk(18'({almost_empty_n_out, almost_full_n_out}), 18'h0_0003);
    rd();
    chk(q_pins, 18'h0_0201);
    chk(18'(almost_empty_n_out), 18'h0_0000);
    $display("test asynchronous flags done");
    stop_test();
  end
endmodule : test_dual_clock_flagged_fifo
bind dcf_fifo dcf_fifo_monitor u_mon (
  .core_clk_in(core_clk_in),
  .rd_clk_in(rd_clk_in),
  .rst_b_in(rst_b_in),
  .write_enable_n_in(write_enable_n_in),
  .read_enable_n_in(read_enable_n_in),
  .load_n_in(load_n_in),
  .output_enable_n_in(output_enable_n_in),
  .read_cascade_in(read_cascade_in),
  .read_data_out(read_data_out),
  .read_data_oe_out(read_data_oe_out),
  .empty_flag_n_out(empty_flag_n_out),
  .full_flag_n_out(full_flag_n_out),
  .half_full_n_out(half_full_n_out),
  .almost_empty_n_out(almost_empty_n_out),
  .almost_full_n_out(almost_full_n_out)
);
